/* File: cpu_ctl_pkg.sv */
// Shared constants and types for the CPU stack and reset control block.
package cpu_ctl_pkg;

  localparam int CLK_MHZ = 200;
  localparam int POR_FIRST_US = 1000;
  localparam int POR_EXT_US = 95000;
  localparam int WDR_HOLD_US = 2000;
  localparam int WDT_TIMEOUT_US = 8000;
  localparam int POR_FIRST_CYC = POR_FIRST_US * CLK_MHZ;
  localparam int POR_EXT_CYC = POR_EXT_US * CLK_MHZ;
  localparam int WDR_HOLD_CYC = WDR_HOLD_US * CLK_MHZ;
  localparam int WDT_TIMEOUT_CYC = WDT_TIMEOUT_US * CLK_MHZ;
  localparam int CNT_W = 25;

  localparam logic [2:0] REG_STATUS = 3'h0;
  localparam logic [2:0] REG_WDT_CLEAR = 3'h1;
  localparam logic [2:0] REG_INT_EN = 3'h2;
  localparam logic [2:0] REG_USB_ADDR = 3'h3;
  localparam logic [2:0] REG_BR_PEND = 3'h4;
  localparam logic [2:0] REG_DSP = 3'h5;

  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_POR_BIT = 4;
  localparam int STAT_WDR_BIT = 6;
  localparam int BR_EN_BIT = 0;
  localparam int BR_PEND_BIT = 0;
  localparam logic [7:0] STATUS_POR_RST = 8'h11;
  localparam logic [7:0] STATUS_WDR_PAT = 8'h41;
  localparam logic [7:0] STATUS_CAUSE_MASK = 8'h50;
  localparam logic [7:0] PSP_RST = 8'h00;
  localparam logic [7:0] DSP_RST = 8'h00;
  localparam logic [7:0] REG8_RST = 8'h00;
  localparam logic [13:0] PC_RST = 14'h0000;

  typedef enum logic [3:0] {
    OP_NONE, OP_INT_ACK, OP_CALL, OP_RET, OP_RETURN_FROM_INTERRUPT, OP_PUSH, OP_POP,
    OP_LOAD_PSP, OP_SWAP_DSP, OP_FETCH, OP_EI, OP_DI
  } op_e;

  typedef enum logic [1:0] {
    AM_DATA, AM_DIRECT, AM_INDEX
  } addr_mode_e;

endpackage

/* File: cpu_stack_reset_ctrl.sv */
// Stack pointers, operand addressing and reset sequencing of the CPU core.
// Function
// - Reset clears program stack pointer; grows upward.
// - Program stack pointer loaded from accumulator only.
// - Interrupt entry disables interrupts, pushes two bytes.
// - Return from interrupt pops two bytes, re-enables.
// - Call pushes counter and flags, pointer plus two.
// - Return restores counter only, pointer minus two.
// - Push pre-decrements data stack pointer, then writes.
// - Pop reads at pointer, then post-increments.
// - Data stack pointer resets zero, wraps modulo 256.
// - Immediate mode takes second instruction byte directly.
// - Direct mode uses second byte as address.
// - Indexed address is constant plus index, 8-bit.
// - Both resets restore defaults and clear pointers.
// - Status bit 4 marks power-on, bit 6 watchdog.
// - After reset start at zero, nothing pushed.
// - Power-on holds CPU 1 ms then 95 ms.
// - Bus reset during extended hold starts execution.
// - Cut-short bus reset stays pending until enabled.
// - Watchdog clear write restarts; rollover resets device.
// - Watchdog reset loads status pattern, sets bit 6.
// - Watchdog reset lasts 2 ms, then address zero.
// - Stacked value is next instruction address plus flags.
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module cpu_stack_reset_ctrl
  import cpu_ctl_pkg::*;
#(
  parameter int POR_FIRST_CYCLES = POR_FIRST_CYC,
  parameter int POR_EXT_CYCLES = POR_EXT_CYC,
  parameter int WDR_HOLD_CYCLES = WDR_HOLD_CYC,
  parameter int WDT_TIMEOUT_CYCLES = WDT_TIMEOUT_CYC
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire op_e OP_I,
  input wire logic OP_VALID_I,
  input wire addr_mode_e MODE_I,
  input wire logic [7:0] OPERAND_BYTE_I,
  input wire logic [7:0] ACC_I,
  input wire logic [7:0] X_I,
  input wire logic [13:0] PC_I,
  input wire logic CARRY_I,
  input wire logic ZERO_I,
  input wire logic USB_BUS_RESET_I,
  input wire logic [2:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RAM_RDATA_I,
  output logic [7:0] RDATA_O,
  output logic OP_READY_O,
  output logic [7:0] RAM_ADDR_O,
  output logic [7:0] RAM_WDATA_O,
  output logic RAM_WE_O,
  output logic RAM_RE_O,
  output logic [7:0] OPERAND_O,
  output logic OPERAND_VALID_O,
  output logic PC_LOAD_O,
  output logic [13:0] PC_O,
  output logic FLAGS_LOAD_O,
  output logic CARRY_O,
  output logic ZERO_O,
  output logic GIE_O,
  output logic BUS_RESET_IRQ_O,
  output logic CPU_RUN_O,
  output logic CORE_RESET_O,
  output logic [7:0] USB_ADDR_O
);

  typedef enum logic [1:0] {PH_FIRST, PH_EXT, PH_RUN, PH_WDR} phase_e;
  typedef enum logic [3:0] {
    ST_IDLE, ST_PWR_LO, ST_PWR_HI, ST_PRD_HI, ST_PRD_LO, ST_PRD_FIN,
    ST_DPUSH, ST_DPOP, ST_DPOP_FIN, ST_FETCH, ST_FETCH_FIN
  } seq_e;

  phase_e phase_q;
  seq_e state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] wdt_q;
  logic start_q;
  logic br_meta_q, br_sync_q, br_prev_q;
  logic br_edge;
  logic wdt_roll;
  logic wdt_clear;
  logic op_take;
  logic [7:0] psp_q, dsp_q, ram_addr_q;
  logic [7:0] push_lo_q, push_hi_q, pop_hi_q, dpush_q;
  logic is_return_from_interrupt_q;
  logic gie_q;
  logic [7:0] status_q, int_en_q, usb_addr_q;
  logic br_pend_q;
  logic pc_load_q, flags_load_q, operand_valid_q;
  logic [13:0] pc_q;
  logic carry_q, zero_q;
  logic [7:0] operand_q, rdata_q;

  // The bus reset pin is asynchronous to the core clock.
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      br_meta_q <= 1'b0;
      br_sync_q <= 1'b0;
      br_prev_q <= 1'b0;
    end else begin
      br_meta_q <= USB_BUS_RESET_I;
      br_sync_q <= br_meta_q;
      br_prev_q <= br_sync_q;
    end
  end

  assign br_edge = br_sync_q && !br_prev_q;
  assign wdt_clear = WR_I && (ADDR_I == REG_WDT_CLEAR);
  assign wdt_roll = (phase_q == PH_RUN) && (wdt_q == CNT_W'(WDT_TIMEOUT_CYCLES - 1));
  assign op_take = OP_VALID_I && (state_q == ST_IDLE) && (phase_q == PH_RUN);

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      phase_q <= PH_FIRST;
      cnt_q <= '0;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      cnt_q <= cnt_q + 1'b1;
      case (phase_q)
        PH_FIRST: begin
          if (cnt_q == CNT_W'(POR_FIRST_CYCLES - 1)) begin
            phase_q <= PH_EXT;
            cnt_q <= '0;
          end
        end
        PH_EXT: begin
          if (br_edge || cnt_q == CNT_W'(POR_EXT_CYCLES - 1)) begin
            phase_q <= PH_RUN;
            start_q <= 1'b1;
          end
        end
        PH_RUN: begin
          cnt_q <= '0;
          if (wdt_roll) begin
            phase_q <= PH_WDR;
          end
        end
        PH_WDR: begin
          if (cnt_q == CNT_W'(WDR_HOLD_CYCLES - 1)) begin
            phase_q <= PH_RUN;
            start_q <= 1'b1;
          end
        end
        default: phase_q <= PH_FIRST;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      wdt_q <= '0;
    end else if (phase_q != PH_RUN || wdt_clear || wdt_roll) begin
      wdt_q <= '0;
    end else begin
      wdt_q <= wdt_q + 1'b1;
    end
  end

  // Stack and operand sequencer; the whole watchdog hold keeps it at defaults.
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_q <= ST_IDLE;
      psp_q <= PSP_RST;
      dsp_q <= DSP_RST;
      ram_addr_q <= REG8_RST;
      push_lo_q <= REG8_RST;
      push_hi_q <= REG8_RST;
      pop_hi_q <= REG8_RST;
      dpush_q <= REG8_RST;
      is_return_from_interrupt_q <= 1'b0;
    end else if (phase_q != PH_RUN) begin
      state_q <= ST_IDLE;
      psp_q <= PSP_RST;
      dsp_q <= DSP_RST;
      is_return_from_interrupt_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (op_take) begin
            case (OP_I)
              OP_INT_ACK, OP_CALL: begin
                push_lo_q <= PC_I[7:0];
                push_hi_q <= {CARRY_I, ZERO_I, PC_I[13:8]};
                state_q <= ST_PWR_LO;
              end
              OP_RET, OP_RETURN_FROM_INTERRUPT: begin
                psp_q <= psp_q - 8'h01;
                is_return_from_interrupt_q <= (OP_I == OP_RETURN_FROM_INTERRUPT);
                state_q <= ST_PRD_HI;
              end
              OP_PUSH: begin
                dsp_q <= dsp_q - 8'h01;
                dpush_q <= OPERAND_BYTE_I;
                state_q <= ST_DPUSH;
              end
              OP_POP: state_q <= ST_DPOP;
              OP_LOAD_PSP: psp_q <= ACC_I;
              OP_SWAP_DSP: dsp_q <= ACC_I;
              OP_FETCH: begin
                ram_addr_q <= (MODE_I == AM_INDEX) ? 8'(OPERAND_BYTE_I + X_I) : OPERAND_BYTE_I;
                if (MODE_I != AM_DATA) begin
                  state_q <= ST_FETCH;
                end
              end
              default: state_q <= ST_IDLE;
            endcase
          end
        end
        ST_PWR_LO: begin
          psp_q <= psp_q + 8'h01;
          state_q <= ST_PWR_HI;
        end
        ST_PWR_HI: begin
          psp_q <= psp_q + 8'h01;
          state_q <= ST_IDLE;
        end
        ST_PRD_HI: begin
          psp_q <= psp_q - 8'h01;
          state_q <= ST_PRD_LO;
        end
        ST_PRD_LO: begin
          pop_hi_q <= RAM_RDATA_I;
          state_q <= ST_PRD_FIN;
        end
        ST_PRD_FIN: state_q <= ST_IDLE;
        ST_DPUSH: state_q <= ST_IDLE;
        ST_DPOP: begin
          dsp_q <= dsp_q + 8'h01;
          state_q <= ST_DPOP_FIN;
        end
        ST_DPOP_FIN: state_q <= ST_IDLE;
        ST_FETCH: state_q <= ST_FETCH_FIN;
        ST_FETCH_FIN: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_comb begin
    RAM_WE_O = 1'b0;
    RAM_RE_O = 1'b0;
    RAM_ADDR_O = psp_q;
    RAM_WDATA_O = push_lo_q;
    case (state_q)
      ST_PWR_LO: RAM_WE_O = 1'b1;
      ST_PWR_HI: begin
        RAM_WE_O = 1'b1;
        RAM_WDATA_O = push_hi_q;
      end
      ST_PRD_HI, ST_PRD_LO: RAM_RE_O = 1'b1;
      ST_DPUSH: begin
        RAM_WE_O = 1'b1;
        RAM_ADDR_O = dsp_q;
        RAM_WDATA_O = dpush_q;
      end
      ST_DPOP: begin
        RAM_RE_O = 1'b1;
        RAM_ADDR_O = dsp_q;
      end
      ST_FETCH: begin
        RAM_RE_O = 1'b1;
        RAM_ADDR_O = ram_addr_q;
      end
      default: RAM_ADDR_O = psp_q;
    endcase
  end

  // Results back to the core: restored counter, flags and operand bytes.
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pc_load_q <= 1'b0;
      flags_load_q <= 1'b0;
      pc_q <= PC_RST;
      carry_q <= 1'b0;
      zero_q <= 1'b0;
      operand_q <= REG8_RST;
      operand_valid_q <= 1'b0;
    end else begin
      pc_load_q <= start_q;
      flags_load_q <= 1'b0;
      operand_valid_q <= 1'b0;
      if (start_q) begin
        pc_q <= PC_RST;
      end
      if (state_q == ST_PRD_FIN) begin
        pc_q <= {pop_hi_q[5:0], RAM_RDATA_I};
        pc_load_q <= 1'b1;
        flags_load_q <= is_return_from_interrupt_q;
        carry_q <= is_return_from_interrupt_q ? pop_hi_q[7] : carry_q;
        zero_q <= is_return_from_interrupt_q ? pop_hi_q[6] : zero_q;
      end
      if (state_q == ST_DPOP_FIN || state_q == ST_FETCH_FIN) begin
        operand_q <= RAM_RDATA_I;
        operand_valid_q <= 1'b1;
      end
      if (op_take && OP_I == OP_FETCH && MODE_I == AM_DATA) begin
        operand_q <= OPERAND_BYTE_I;
        operand_valid_q <= 1'b1;
      end
      if (op_take && OP_I == OP_SWAP_DSP) begin
        operand_q <= dsp_q;
        operand_valid_q <= 1'b1;
      end
    end
  end

  // acknowledge disables / re-enable after restore
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      gie_q <= 1'b0;
    end else if (phase_q != PH_RUN) begin
      gie_q <= 1'b0;
    end else if (state_q == ST_PRD_FIN && is_return_from_interrupt_q) begin
      gie_q <= 1'b1;
    end else if (op_take && (OP_I == OP_INT_ACK || OP_I == OP_DI)) begin
      gie_q <= 1'b0;
    end else if (op_take && OP_I == OP_EI) begin
      gie_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      status_q <= STATUS_POR_RST;
    end else if (wdt_roll) begin
      // The power-on cause bit is left as it was; it is the undefined one.
      status_q <= STATUS_WDR_PAT | (status_q & (8'h01 << STAT_POR_BIT));
    end else if (phase_q == PH_RUN && WR_I && ADDR_I == REG_STATUS) begin
      // Cause bits clear on a one; other bits take the written value.
      status_q <= (WDATA_I & ~STATUS_CAUSE_MASK) | (status_q & STATUS_CAUSE_MASK & ~WDATA_I);
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      int_en_q <= REG8_RST;
      usb_addr_q <= REG8_RST;
    end else if (phase_q != PH_RUN) begin
      int_en_q <= REG8_RST;
      usb_addr_q <= REG8_RST;
    end else if (WR_I && ADDR_I == REG_INT_EN) begin
      int_en_q <= WDATA_I;
    end else if (WR_I && ADDR_I == REG_USB_ADDR) begin
      usb_addr_q <= WDATA_I;
    end
  end

  // bus reset stays pending; set wins over clear
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      br_pend_q <= 1'b0;
    end else if (br_edge && (phase_q == PH_EXT || phase_q == PH_RUN)) begin
      br_pend_q <= 1'b1;
    end else if (phase_q == PH_WDR) begin
      br_pend_q <= 1'b0;
    end else if (WR_I && ADDR_I == REG_BR_PEND && WDATA_I[BR_PEND_BIT]) begin
      br_pend_q <= 1'b0;
    end
  end

  // The program stack pointer is deliberately absent from the read map.
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rdata_q <= REG8_RST;
    end else begin
      rdata_q <= REG8_RST;
      if (RD_I) begin
        case (ADDR_I)
          REG_STATUS: rdata_q <= status_q;
          REG_INT_EN: rdata_q <= int_en_q;
          REG_USB_ADDR: rdata_q <= usb_addr_q;
          REG_BR_PEND: rdata_q <= {7'h00, br_pend_q};
          REG_DSP: rdata_q <= dsp_q;
          default: rdata_q <= REG8_RST;
        endcase
      end
    end
  end

  assign RDATA_O = rdata_q;
  assign OP_READY_O = (state_q == ST_IDLE) && (phase_q == PH_RUN);
  assign OPERAND_O = operand_q;
  assign OPERAND_VALID_O = operand_valid_q;
  assign PC_LOAD_O = pc_load_q;
  assign PC_O = pc_q;
  assign FLAGS_LOAD_O = flags_load_q;
  assign CARRY_O = carry_q;
  assign ZERO_O = zero_q;
  assign GIE_O = gie_q;
  assign BUS_RESET_IRQ_O = br_pend_q && int_en_q[BR_EN_BIT] && gie_q;
  assign CPU_RUN_O = (phase_q == PH_RUN);
  assign CORE_RESET_O = (phase_q == PH_WDR);
  assign USB_ADDR_O = usb_addr_q;

  sequence s_take(op_e o);
    op_take && OP_I == o;
  endsequence

  chk_psp_reset: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (phase_q == PH_WDR) |=> (psp_q == PSP_RST && dsp_q == DSP_RST))
    else $error("stack pointers not cleared during reset");

  chk_call_push: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    s_take(OP_CALL) |=> (RAM_WE_O && RAM_ADDR_O == $past(psp_q)) ##1 RAM_WE_O
      ##1 (psp_q == 8'($past(psp_q, 3) + 8'h02)))
    else $error("call did not push two bytes");

  chk_intack_gie: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    s_take(OP_INT_ACK) |=> !gie_q [*2] ##1 (psp_q == 8'($past(psp_q, 3) + 8'h02)))
    else $error("interrupt entry wrong");

  chk_return_from_interrupt_restore: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    s_take(OP_RETURN_FROM_INTERRUPT) |-> ##4 (PC_LOAD_O && FLAGS_LOAD_O && gie_q
      && psp_q == 8'($past(psp_q, 4) - 8'h02)))
    else $error("interrupt return wrong");

  chk_ret_noflags: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    s_take(OP_RET) |-> ##4 (PC_LOAD_O && !FLAGS_LOAD_O))
    else $error("subroutine return touched flags");

  chk_push_predec: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    s_take(OP_PUSH) |=> (RAM_WE_O && RAM_ADDR_O == 8'($past(dsp_q) - 8'h01)))
    else $error("push address not pre-decremented");

  chk_pop_postinc: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    s_take(OP_POP) |=> (RAM_RE_O && RAM_ADDR_O == $past(dsp_q))
      ##1 (dsp_q == 8'($past(dsp_q, 2) + 8'h01)))
    else $error("pop not post-incremented");

  chk_index_addr: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (s_take(OP_FETCH) ##0 (MODE_I == AM_INDEX))
      |=> (RAM_RE_O && RAM_ADDR_O == 8'($past(OPERAND_BYTE_I) + $past(X_I))))
    else $error("indexed address wrong");

  chk_imm_operand: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (s_take(OP_FETCH) ##0 (MODE_I == AM_DATA))
      |=> (OPERAND_VALID_O && OPERAND_O == $past(OPERAND_BYTE_I) && !RAM_RE_O))
    else $error("immediate operand wrong");

  chk_wdr_status: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    wdt_roll |=> (CORE_RESET_O && status_q[STAT_WDR_BIT] && status_q[STAT_RUN_BIT]))
    else $error("watchdog reset status wrong");

  chk_busrst_abort: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (phase_q == PH_EXT && br_edge) |=> (CPU_RUN_O && br_pend_q) ##1 (PC_LOAD_O && PC_O == PC_RST))
    else $error("bus reset did not end the hold");

endmodule

/* File: data_ram_model.sv */
// Behavioural model of the 256-byte data RAM that holds both stacks.
`timescale 1ns/100ps
module data_ram_model (
  input wire logic clk_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [256];
  initial rdata_o = 8'h00;
  // Outside a read the data lines flip every cycle, so stale data never passes for a reply.
  always @(posedge clk_i) begin
    if (we_i) mem[addr_i] <= wdata_i;
    if (re_i) rdata_o <= mem[addr_i];
    else rdata_o <= ~rdata_o;
  end
endmodule

/* File: tb.sv */
// Self-checking testbench for the CPU stack and reset control block.
`timescale 1ns/100ps
module tb;
  import cpu_ctl_pkg::*;
  // Shortened counts keep the run brief; every timing expectation derives from these.
  localparam int POR_F = 20;
  localparam int POR_E = 50;
  localparam int WDR_H = 30;
  localparam int WDT_TO = 400;
  localparam logic [7:0] FB [3] = '{8'h77, 8'h40, 8'hF0};
  localparam logic [7:0] FE [3] = '{8'h77, 8'hA5, 8'h3C};
  logic CLK_I = 1'b0;
  logic RSTN_I = 1'b0;
  op_e OP_I = OP_NONE;
  logic OP_VALID_I = 1'b0;
  addr_mode_e MODE_I = AM_DATA;
  logic [7:0] OPERAND_BYTE_I = 8'h00;
  logic [7:0] ACC_I = 8'h00;
  logic [7:0] X_I = 8'h00;
  logic [13:0] PC_I = 14'h0000;
  logic CARRY_I = 1'b0;
  logic ZERO_I = 1'b0;
  logic USB_BUS_RESET_I = 1'b0;
  logic [2:0] ADDR_I = 3'h0;
  logic [7:0] WDATA_I = 8'h00;
  logic WR_I = 1'b0;
  logic RD_I = 1'b0;
  logic [7:0] RAM_RDATA_I, RDATA_O, RAM_ADDR_O, RAM_WDATA_O, OPERAND_O, USB_ADDR_O;
  logic OP_READY_O, RAM_WE_O, RAM_RE_O, OPERAND_VALID_O, PC_LOAD_O, FLAGS_LOAD_O;
  logic CARRY_O, ZERO_O, GIE_O, BUS_RESET_IRQ_O, CPU_RUN_O, CORE_RESET_O;
  logic [13:0] PC_O;
  logic [13:0] pc_seen;
  logic [7:0] opnd_seen;
  int n_fail = 0;
  int num_checks = 0;
  int n_fl = 0;
  int n_we = 0;
  int n_wdr = 0;

  always #2.5 CLK_I = ~CLK_I;

  cpu_stack_reset_ctrl #(.POR_FIRST_CYCLES(POR_F), .POR_EXT_CYCLES(POR_E),
    .WDR_HOLD_CYCLES(WDR_H), .WDT_TIMEOUT_CYCLES(WDT_TO)) i_cpu_stack_reset_ctrl (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .OP_I(OP_I), .OP_VALID_I(OP_VALID_I),
    .MODE_I(MODE_I), .OPERAND_BYTE_I(OPERAND_BYTE_I), .ACC_I(ACC_I), .X_I(X_I),
    .PC_I(PC_I), .CARRY_I(CARRY_I), .ZERO_I(ZERO_I), .USB_BUS_RESET_I(USB_BUS_RESET_I),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
    .RAM_RDATA_I(RAM_RDATA_I), .RDATA_O(RDATA_O), .OP_READY_O(OP_READY_O),
    .RAM_ADDR_O(RAM_ADDR_O), .RAM_WDATA_O(RAM_WDATA_O), .RAM_WE_O(RAM_WE_O),
    .RAM_RE_O(RAM_RE_O), .OPERAND_O(OPERAND_O), .OPERAND_VALID_O(OPERAND_VALID_O),
    .PC_LOAD_O(PC_LOAD_O), .PC_O(PC_O), .FLAGS_LOAD_O(FLAGS_LOAD_O), .CARRY_O(CARRY_O),
    .ZERO_O(ZERO_O), .GIE_O(GIE_O), .BUS_RESET_IRQ_O(BUS_RESET_IRQ_O),
    .CPU_RUN_O(CPU_RUN_O), .CORE_RESET_O(CORE_RESET_O), .USB_ADDR_O(USB_ADDR_O));

  data_ram_model i_data_ram_model (.clk_i(CLK_I), .addr_i(RAM_ADDR_O),
    .wdata_i(RAM_WDATA_O), .we_i(RAM_WE_O), .re_i(RAM_RE_O), .rdata_o(RAM_RDATA_I));

  always @(posedge CLK_I) begin
    if (PC_LOAD_O === 1'b1) pc_seen <= PC_O;
    if (OPERAND_VALID_O === 1'b1) opnd_seen <= OPERAND_O;
    if (FLAGS_LOAD_O === 1'b1) n_fl++;
    if (RAM_WE_O === 1'b1) n_we++;
    if (CORE_RESET_O === 1'b1) n_wdr++;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge CLK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge CLK_I);
    WR_I <= 1'b0;
  endtask

  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge CLK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge CLK_I);
    RD_I <= 1'b0;
    @(posedge CLK_I);
    d = RDATA_O;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e, input string what);
    logic [7:0] d;
    reg_rd(a, d);
    check(16'(d), 16'(e), what);
  endtask

  // Waits for the sequencer to go idle, then issues one operation and lets it finish.
  task automatic do_op(input op_e op);
    int k;
    k = 0;
    while (OP_READY_O !== 1'b1 && k < 50) begin
      @(posedge CLK_I);
      k++;
    end
    check(16'(k < 50), 16'h1, "op ready");
    @(posedge CLK_I);
    OP_I <= op;
    OP_VALID_I <= 1'b1;
    @(posedge CLK_I);
    OP_VALID_I <= 1'b0;
    repeat (6) @(posedge CLK_I);
  endtask

  task automatic por(input bit bus, output int cyc);
    pc_seen = 14'h3FFF;
    @(posedge CLK_I);
    RSTN_I <= 1'b0;
    repeat (8) @(posedge CLK_I);
    RSTN_I <= 1'b1;
    cyc = 0;
    while (CPU_RUN_O !== 1'b1 && cyc < 500) begin
      @(posedge CLK_I);
      cyc++;
      if (bus && cyc == POR_F + 10) USB_BUS_RESET_I <= 1'b1;
      if (cyc == POR_F + 14) USB_BUS_RESET_I <= 1'b0;
    end
    repeat (3) @(posedge CLK_I);
  endtask

  initial begin
    repeat (20000) @(posedge CLK_I);
    n_fail++;
    end_of_test();
  end

  initial begin
    logic [7:0] d;
    int cyc;
    int w0;
    i_data_ram_model.mem[8'h40] = 8'hA5;
    i_data_ram_model.mem[8'h03] = 8'h3C;
    w0 = n_we;
    por(1'b0, cyc);
    check(16'(cyc >= POR_F + POR_E && cyc <= POR_F + POR_E + 3), 16'h1, "hold");
    check(16'(pc_seen), 16'h0000, "start pc");
    check(16'(n_we - w0), 16'h0000, "reset push");
    rd_chk(REG_STATUS, STATUS_POR_RST, "por status");
    rd_chk(REG_DSP, DSP_RST, "dsp");
    rd_chk(REG_USB_ADDR, REG8_RST, "usb addr");
    rd_chk(3'h6, 8'h00, "unmapped");
    rd_chk(REG_WDT_CLEAR, 8'h00, "write only");
    check(16'(GIE_O), 16'h0000, "gie");
    reg_wr(REG_STATUS, 8'h11);
    rd_chk(REG_STATUS, 8'h01, "cause clear");
    $display("test reset done");
    reg_wr(REG_WDT_CLEAR, 8'h00);
    ACC_I <= 8'h10;
    do_op(OP_LOAD_PSP);
    PC_I <= 14'h2ABC;
    CARRY_I <= 1'b1;
    do_op(OP_CALL);
    check({i_data_ram_model.mem[8'h11], i_data_ram_model.mem[8'h10]}, 16'hAABC, "call");
    do_op(OP_EI);
    check(16'(GIE_O), 16'h0001, "ei");
    PC_I <= 14'h0123;
    CARRY_I <= 1'b0;
    ZERO_I <= 1'b1;
    do_op(OP_INT_ACK);
    check(16'(GIE_O), 16'h0000, "ack gie");
    check({i_data_ram_model.mem[8'h13], i_data_ram_model.mem[8'h12]}, 16'h4123, "ack");
    w0 = n_fl;
    do_op(OP_RETURN_FROM_INTERRUPT);
    check({CARRY_O, ZERO_O, pc_seen}, 16'h4123, "return_from_interrupt");
    check(16'(GIE_O), 16'h0001, "return_from_interrupt gie");
    do_op(OP_RET);
    check(16'(pc_seen), 16'h2ABC, "ret pc");
    check(16'(n_fl - w0), 16'h0001, "ret flags");
    PC_I <= 14'h0001;
    do_op(OP_CALL);
    check(16'(i_data_ram_model.mem[8'h10]), 16'h0001, "psp back");
    $display("test program stack done");
    reg_wr(REG_WDT_CLEAR, 8'h00);
    OPERAND_BYTE_I <= 8'h5A;
    do_op(OP_PUSH);
    check(16'(i_data_ram_model.mem[8'hFF]), 16'h005A, "push wrap");
    rd_chk(REG_DSP, 8'hFF, "dsp dec");
    OPERAND_BYTE_I <= 8'h6B;
    do_op(OP_PUSH);
    check(16'(i_data_ram_model.mem[8'hFE]), 16'h006B, "push");
    do_op(OP_POP);
    check(16'(opnd_seen), 16'h006B, "pop");
    do_op(OP_POP);
    check(16'(opnd_seen), 16'h005A, "pop again");
    rd_chk(REG_DSP, 8'h00, "dsp inc");
    ACC_I <= 8'h20;
    do_op(OP_SWAP_DSP);
    check(16'(opnd_seen), 16'h0000, "swap old");
    rd_chk(REG_DSP, 8'h20, "swap new");
    X_I <= 8'h13;
    for (int m = 0; m < 3; m++) begin
      MODE_I <= addr_mode_e'(m);
      OPERAND_BYTE_I <= FB[m];
      do_op(OP_FETCH);
      check(16'(opnd_seen), 16'(FE[m]), "fetch");
    end
    $display("test data stack done");
    reg_wr(REG_USB_ADDR, 8'h55);
    reg_wr(REG_INT_EN, 8'h01);
    w0 = n_wdr;
    repeat (3) begin
      repeat (WDT_TO - 100) @(posedge CLK_I);
      reg_wr(REG_WDT_CLEAR, 8'hC3);
    end
    check(16'(n_wdr - w0), 16'h0000, "wdt cleared");
    cyc = 0;
    while (CORE_RESET_O !== 1'b1 && cyc < 1000) begin
      @(posedge CLK_I);
      cyc++;
    end
    check(16'(cyc >= WDT_TO - 2 && cyc <= WDT_TO + 4), 16'h1, "wdt expiry");
    pc_seen = 14'h3FFF;
    cyc = 0;
    while (CPU_RUN_O !== 1'b1 && cyc < 500) begin
      @(posedge CLK_I);
      cyc++;
    end
    repeat (3) @(posedge CLK_I);
    check(16'(n_wdr - w0), 16'(WDR_H), "wdr hold");
    check(16'(pc_seen), 16'h0000, "wdr pc");
    reg_rd(REG_STATUS, d);
    check(16'(d), 16'(STATUS_WDR_PAT), "wdr status");
    check(16'(d[STAT_WDR_BIT] & ~d[STAT_POR_BIT]), 16'h1, "wdr cause");
    check(16'(USB_ADDR_O), 16'h0000, "usb cleared");
    rd_chk(REG_INT_EN, 8'h00, "int en");
    PC_I <= 14'h0155;
    do_op(OP_CALL);
    check(16'(i_data_ram_model.mem[8'h00]), 16'h0055, "psp zero");
    $display("test watchdog done");
    por(1'b1, cyc);
    check(16'(cyc >= POR_F + 11 && cyc <= POR_F + 16), 16'h1, "bypass");
    check(16'(pc_seen), 16'h0000, "bypass pc");
    rd_chk(REG_BR_PEND, 8'h01, "pending");
    reg_wr(REG_INT_EN, 8'h01);
    repeat (2) @(posedge CLK_I);
    check(16'(BUS_RESET_IRQ_O), 16'h0000, "no gie");
    do_op(OP_EI);
    check(16'(BUS_RESET_IRQ_O), 16'h0001, "irq");
    do_op(OP_DI);
    check(16'(GIE_O), 16'h0000, "di");
    check(16'(BUS_RESET_IRQ_O), 16'h0000, "di irq");
    reg_wr(REG_BR_PEND, 8'h01);
    rd_chk(REG_BR_PEND, 8'h00, "pend clear");
    $display("test bus reset done");
    end_of_test();
  end
endmodule
